// *** verilog/spm_pkg.sv ***
// constants and types shared by the serial port master/slave block
// assumes one system clock domain; pins are synchronised inside the top module

package spm_pkg;

	// ---------------------------------------------------------------
	// widths
	// ---------------------------------------------------------------
	localparam int CHAR_W     = 16;
	localparam int EDGE_W     = 5;
	localparam int HALF_W     = 8;
	localparam int FIFO_DEPTH = 16;
	localparam int LVL_W      = 5;

	// ---------------------------------------------------------------
	// fixed values
	// ---------------------------------------------------------------
	localparam logic [4:0]        CHAR_MAX   = 5'h10;
	localparam logic [4:0]        EDGE_ZERO  = 5'h00;
	localparam logic [5:0]        EDGE_ONE   = 6'h01;
	localparam logic [HALF_W-1:0] HALF_ONE   = 8'h01;
	localparam logic [LVL_W-1:0]  TX_RDY_MAX = 5'h0E;

	// ---------------------------------------------------------------
	// engine states
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_SELECT = 3'b001,
		ST_SHIFT  = 3'b010,
		ST_TAIL   = 3'b011,
		ST_SLAVE  = 3'b100
	} spm_state_t;

endpackage

// *** verilog/spm_sync.sv ***
// two flip-flop synchroniser for pin inputs
// assumes inputs are asynchronous to clk
`timescale 1ns/1ns
`default_nettype none

module spm_sync #(
	parameter int WIDTH = 4
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// data
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} spm_sync_st_t;

	spm_sync_st_t st_reg;
	spm_sync_st_t st_next;

	always_comb begin
		st_next    = st_reg;
		st_next.s1 = din;
		st_next.s2 = st_reg.s1;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign dout = st_reg.s2;
endmodule // spm_sync

`default_nettype wire

// *** verilog/spm_fifo.sv ***
// flip-flop queue with level, full and empty
// assumes push is only given while not full, pop only while not empty
`timescale 1ns/1ns
`default_nettype none

module spm_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16,
	parameter int AW    = 4,
	parameter int LW    = 5
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// fill side
	input  wire logic             push,
	input  wire logic [WIDTH-1:0] push_data,
	// drain side
	input  wire logic             pop,
	output logic      [WIDTH-1:0] pop_data,
	// status
	output logic      [LW-1:0]    level,
	output logic                  full,
	output logic                  empty
);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [LW-1:0]               cnt;
	} spm_fifo_st_t;

	spm_fifo_st_t st_reg;
	spm_fifo_st_t st_next;
	logic         do_push;
	logic         do_pop;

	assign full     = (st_reg.cnt == LW'(DEPTH));
	assign empty    = (st_reg.cnt == '0);
	assign do_push  = push && !full;
	assign do_pop   = pop && !empty;
	assign pop_data = st_reg.mem[st_reg.rp];
	assign level    = st_reg.cnt;

	always_comb begin
		st_next = st_reg;
		if (do_push) begin
			st_next.mem[st_reg.wp] = push_data;
			st_next.wp             = AW'(st_reg.wp + 1'b1);
		end
		if (do_pop) begin
			st_next.rp = AW'(st_reg.rp + 1'b1);
		end
		if (do_push && !do_pop) begin
			st_next.cnt = LW'(st_reg.cnt + 1'b1);
		end else if (do_pop && !do_push) begin
			st_next.cnt = LW'(st_reg.cnt - 1'b1);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
endmodule // spm_fifo

`default_nettype wire

// *** verilog/spm_port.sv ***
// serial port engine: master or slave, three or four wire, with tx and rx queues
// assumes config ports are changed only while PORT_EN is low; pins sampled through two flops
`timescale 1ns/1ns
`default_nettype none

module spm_port
	import spm_pkg::*;
#(
	parameter int DEPTH = spm_pkg::FIFO_DEPTH
) (
	// clock and reset
	input  wire logic                      CLK_SYS,
	input  wire logic                      RST_N,
	// configuration
	input  wire logic                      PORT_EN,
	input  wire logic                      MASTER_SEL,
	input  wire logic                      SS_DIR_OUT,
	input  wire logic                      SS_OUT_EN,
	input  wire logic                      THREE_WIRE,
	input  wire logic                      CLK_PHA,
	input  wire logic                      CLK_POL,
	input  wire logic [4:0]                CHAR_BITS,
	input  wire logic [spm_pkg::HALF_W-1:0] SCK_HI,
	input  wire logic [spm_pkg::HALF_W-1:0] SCK_LO,
	input  wire logic                      TX_FIFO_EN,
	input  wire logic                      RX_FIFO_EN,
	input  wire logic [spm_pkg::LVL_W-1:0] TX_WAKE_LVL,
	input  wire logic [spm_pkg::LVL_W-1:0] RX_WAKE_LVL,
	// control and status
	input  wire logic                      START,
	output logic                           BUSY,
	output logic                           WAKE,
	output logic [spm_pkg::LVL_W-1:0]      TX_LEVEL,
	output logic [spm_pkg::LVL_W-1:0]      RX_LEVEL,
	// transmit queue fill side
	input  wire logic                      TX_WR_VALID,
	input  wire logic [spm_pkg::CHAR_W-1:0] TX_WR_DATA,
	output logic                           TX_WR_READY,
	// receive queue drain side
	output logic                           RX_RD_VALID,
	output logic [spm_pkg::CHAR_W-1:0]     RX_RD_DATA,
	input  wire logic                      RX_RD_READY,
	// serial clock pin
	input  wire logic                      SCK_I,
	output logic                           SCK_O,
	output logic                           SCK_OE,
	// master-out / shared data pin
	input  wire logic                      MOSI_I,
	output logic                           MOSI_O,
	output logic                           MOSI_OE,
	// master-in pin
	input  wire logic                      MISO_I,
	output logic                           MISO_O,
	output logic                           MISO_OE,
	// slave select pin, active low
	input  wire logic                      SS_N_I,
	output logic                           SS_N_O,
	output logic                           SS_N_OE
);
	import spm_pkg::*;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		spm_state_t        state;
		logic [HALF_W-1:0] half_cnt;
		logic [EDGE_W-1:0] edge_cnt;
		logic              sck_lvl;
		logic              sck_prev;
		logic [CHAR_W-1:0] tx_sr;
		logic [CHAR_W-1:0] rx_sr;
		logic              rx_valid;
		logic [CHAR_W-1:0] rx_data;
		logic              tx_ready;
		logic [LVL_W-1:0]  tx_level;
		logic [LVL_W-1:0]  rx_level;
		logic              wake;
		logic              busy;
		logic              sck_o;
		logic              sck_oe;
		logic              mosi_o;
		logic              mosi_oe;
		logic              miso_o;
		logic              miso_oe;
		logic              ss_n_o;
		logic              ss_n_oe;
	} spm_port_st_t;

	spm_port_st_t st_reg;
	spm_port_st_t st_next;

	// ---------------------------------------------------------------
	// pin synchronisers and queues
	// ---------------------------------------------------------------
	logic [3:0]        pin_s;
	logic              sck_s;
	logic              ss_n_s;
	logic              mosi_s;
	logic              miso_s;

	spm_sync #(
		.WIDTH (4)
	) u_sync (
		.clk   (CLK_SYS),
		.rst_n (RST_N),
		.din   ({SCK_I, SS_N_I, MOSI_I, MISO_I}),
		.dout  (pin_s)
	);

	assign sck_s  = pin_s[3];
	assign ss_n_s = pin_s[2];
	assign mosi_s = pin_s[1];
	assign miso_s = pin_s[0];

	logic              tx_push;
	logic              tx_pop;
	logic [CHAR_W-1:0] tx_head;
	logic [LVL_W-1:0]  tx_lvl;
	logic              tx_empty;
	logic              rx_push;
	logic [CHAR_W-1:0] rx_word;
	logic              rx_pop;
	logic [CHAR_W-1:0] rx_head;
	logic [LVL_W-1:0]  rx_lvl;
	logic              rx_full;
	logic              rx_empty;

	// 16-bit entries, sixteen deep: thirty-two bytes each way
	spm_fifo #(
		.WIDTH (CHAR_W),
		.DEPTH (DEPTH),
		.AW    ($clog2(DEPTH)),
		.LW    (LVL_W)
	) u_txq (
		.clk       (CLK_SYS),
		.rst_n     (RST_N),
		.push      (tx_push),
		.push_data (TX_WR_DATA),
		.pop       (tx_pop),
		.pop_data  (tx_head),
		.level     (tx_lvl),
		.full      (),
		.empty     (tx_empty)
	);

	spm_fifo #(
		.WIDTH (CHAR_W),
		.DEPTH (DEPTH),
		.AW    ($clog2(DEPTH)),
		.LW    (LVL_W)
	) u_rxq (
		.clk       (CLK_SYS),
		.rst_n     (RST_N),
		.push      (rx_push),
		.push_data (rx_word),
		.pop       (rx_pop),
		.pop_data  (rx_head),
		.level     (rx_lvl),
		.full      (rx_full),
		.empty     (rx_empty)
	);

	// ---------------------------------------------------------------
	// character framing helpers
	// ---------------------------------------------------------------
	logic [4:0]        bits;
	logic [5:0]        edges2;
	logic [EDGE_W-1:0] last_edge;
	logic              tx_avail;
	logic              tx_dir;
	logic              rx_only;
	logic              rx_bit;
	logic [CHAR_W-1:0] load_sr;
	logic              ev;
	logic              lead;
	logic              new_lvl;
	logic [HALF_W-1:0] half_len;
	logic [CHAR_W-1:0] rx_new;
	logic              char_end;
	logic              m_active;
	logic              s_sel;

	assign bits      = (CHAR_BITS == 5'h00 || CHAR_BITS > CHAR_MAX) ? CHAR_MAX : CHAR_BITS;
	assign edges2    = {bits, 1'h0} - EDGE_ONE;
	assign last_edge = edges2[EDGE_W-1:0];
	assign tx_avail  = TX_FIFO_EN && !tx_empty;
	assign tx_dir    = TX_FIFO_EN;
	assign rx_only   = RX_FIFO_EN && !TX_FIFO_EN;
	assign load_sr   = (tx_avail ? tx_head : '0) << (CHAR_MAX - bits);

	// master listens on master-in, or the shared pin in three-wire mode
	always_comb begin
		if (MASTER_SEL && !THREE_WIRE) begin
			rx_bit = miso_s;
		end else begin
			rx_bit = mosi_s;
		end
	end

	assign half_len = st_reg.sck_lvl ? SCK_HI : SCK_LO;

	// ---------------------------------------------------------------
	// engine
	// ---------------------------------------------------------------
	always_comb begin
		st_next  = st_reg;
		tx_pop   = 1'h0;
		rx_push  = 1'h0;
		rx_word  = '0;
		ev       = 1'h0;
		new_lvl  = st_reg.sck_lvl;
		lead     = 1'h0;
		rx_new   = st_reg.rx_sr;
		char_end = 1'h0;

		// serial clock edge from own divider or from the pin
		if (st_reg.state == ST_SHIFT) begin
			if (st_reg.half_cnt + HALF_ONE >= half_len) begin
				ev                = 1'h1;
				new_lvl           = !st_reg.sck_lvl;
				st_next.half_cnt  = '0;
			end else begin
				st_next.half_cnt  = st_reg.half_cnt + HALF_ONE;
			end
		end else if (st_reg.state == ST_SLAVE) begin
			ev               = (sck_s != st_reg.sck_prev);
			new_lvl          = sck_s;
			st_next.sck_prev = sck_s;
		end

		// sample on first edge for phase 0, on second for phase 1
		if (ev) begin
			lead            = (new_lvl != CLK_POL);
			st_next.sck_lvl = new_lvl;
			if (lead ^ CLK_PHA) begin
				rx_new        = {st_reg.rx_sr[CHAR_W-2:0], rx_bit};
				st_next.rx_sr = rx_new;
			end else if (!(lead && st_reg.edge_cnt == EDGE_ZERO)) begin
				st_next.tx_sr = st_reg.tx_sr << 1;
			end
			if (st_reg.edge_cnt == last_edge) begin
				char_end         = 1'h1;
				st_next.edge_cnt = EDGE_ZERO;
				st_next.rx_sr    = '0;
				rx_push          = RX_FIFO_EN && !rx_full;
				rx_word          = rx_new;
			end else begin
				st_next.edge_cnt = st_reg.edge_cnt + 1'h1;
			end
		end

		case (st_reg.state)
			ST_IDLE: begin
				st_next.sck_lvl  = CLK_POL;
				st_next.edge_cnt = EDGE_ZERO;
				st_next.half_cnt = '0;
				st_next.rx_sr    = '0;
				if (PORT_EN && MASTER_SEL && START && (tx_avail || rx_only)) begin
					st_next.state = ST_SELECT;
					st_next.tx_sr = load_sr;
					tx_pop        = tx_avail;
				end else if (PORT_EN && !MASTER_SEL && !ss_n_s) begin
					st_next.state    = ST_SLAVE;
					st_next.sck_prev = sck_s;
					st_next.tx_sr    = load_sr;
					tx_pop           = tx_avail;
				end
			end
			ST_SELECT: begin
				// select held low one low time, then one idle-level half period, before the first clock edge
				if (st_reg.half_cnt + HALF_ONE >= SCK_LO) begin
					st_next.state    = ST_SHIFT;
					st_next.half_cnt = '0;
				end else begin
					st_next.half_cnt = st_reg.half_cnt + HALF_ONE;
				end
			end
			ST_SHIFT: begin
				if (!PORT_EN) begin
					st_next.state = ST_IDLE;
				end else if (char_end) begin
					// read-only runs one character per start
					if (tx_avail && !rx_full) begin
						st_next.tx_sr = load_sr;
						tx_pop        = 1'h1;
					end else begin
						st_next.state = ST_TAIL;
					end
				end
			end
			ST_TAIL: begin
				if (st_reg.half_cnt + HALF_ONE >= SCK_LO) begin
					st_next.state    = ST_IDLE;
					st_next.half_cnt = '0;
				end else begin
					st_next.half_cnt = st_reg.half_cnt + HALF_ONE;
				end
			end
			ST_SLAVE: begin
				if (!PORT_EN || MASTER_SEL || ss_n_s) begin
					st_next.state = ST_IDLE;
				end else if (char_end) begin
					st_next.tx_sr = load_sr;
					tx_pop        = tx_avail;
				end
			end
			default: begin
				st_next.state = ST_IDLE;
			end
		endcase

		// pin drivers
		m_active = (st_next.state == ST_SELECT) || (st_next.state == ST_SHIFT) || (st_next.state == ST_TAIL);
		s_sel    = (st_next.state == ST_SLAVE);

		st_next.sck_oe  = PORT_EN && MASTER_SEL;
		st_next.sck_o   = m_active ? st_next.sck_lvl : CLK_POL;
		st_next.mosi_o  = st_next.tx_sr[CHAR_W-1];
		st_next.miso_o  = st_next.tx_sr[CHAR_W-1];
		if (THREE_WIRE) begin
			st_next.mosi_oe = (m_active || s_sel) && tx_dir;
			st_next.miso_oe = 1'h0;
		end else begin
			st_next.mosi_oe = m_active;
			st_next.miso_oe = s_sel;
		end
		st_next.ss_n_oe = PORT_EN && MASTER_SEL && SS_DIR_OUT && SS_OUT_EN;
		st_next.ss_n_o  = !m_active;

		// queue side status
		st_next.tx_ready = (tx_lvl <= TX_RDY_MAX);
		st_next.tx_level = tx_lvl;
		st_next.rx_level = rx_lvl;
		st_next.wake     = (TX_FIFO_EN && tx_lvl <= TX_WAKE_LVL) ||
		                   (RX_FIFO_EN && rx_lvl >= RX_WAKE_LVL);
		st_next.busy     = (st_next.state != ST_IDLE);

		// receive output stage
		if (rx_pop) begin
			st_next.rx_valid = 1'h1;
			st_next.rx_data  = rx_head;
		end else if (RX_RD_READY) begin
			st_next.rx_valid = 1'h0;
		end
	end

	assign tx_push = TX_WR_VALID && st_reg.tx_ready;
	assign rx_pop  = !rx_empty && (!st_reg.rx_valid || RX_RD_READY);

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign BUSY        = st_reg.busy;
	assign WAKE        = st_reg.wake;
	assign TX_LEVEL    = st_reg.tx_level;
	assign RX_LEVEL    = st_reg.rx_level;
	assign TX_WR_READY = st_reg.tx_ready;
	assign RX_RD_VALID = st_reg.rx_valid;
	assign RX_RD_DATA  = st_reg.rx_data;
	assign SCK_O       = st_reg.sck_o;
	assign SCK_OE      = st_reg.sck_oe;
	assign MOSI_O      = st_reg.mosi_o;
	assign MOSI_OE     = st_reg.mosi_oe;
	assign MISO_O      = st_reg.miso_o;
	assign MISO_OE     = st_reg.miso_oe;
	assign SS_N_O      = st_reg.ss_n_o;
	assign SS_N_OE     = st_reg.ss_n_oe;
endmodule // spm_port

`default_nettype wire

// *** dv/spm_slave_mdl.sv ***
// behavioural external slave device facing the master side of spm_port
// assumes sck and ss_n come from the master; dout feeds master-in or the shared pin
`timescale 1ns/1ns
`default_nettype none

module spm_slave_mdl (
	// link pins
	input  wire logic        sck,
	input  wire logic        ss_n,
	input  wire logic        mosi,
	// mode
	input  wire logic        pol,
	input  wire logic        pha,
	input  wire logic [4:0]  nbits,
	// data
	input  wire logic [15:0] tx_word,
	output logic             dout,
	output logic [15:0]      got
);
	logic [15:0] sh;

	task automatic put;
		dout = sh[15];
		sh = sh << 1;
	endtask

	initial begin
		dout = 1'b0;
		got = 16'h0000;
		sh = 16'h0000;
	end

	// ----------------------------------------
	// select low starts a character, msb first
	// ----------------------------------------
	always @(negedge ss_n) begin
		sh = tx_word << (5'h10 - nbits);
		got = 16'h0000;
		if (!pha)
			put();
	end

	// clock only taken in; sample or shift by mode
	always @(sck) begin
		if (!ss_n) begin
			if (sck ^ pol ^ pha)
				got = {got[14:0], mosi};
			else
				put();
		end
	end

	// released line shows the inverse of its last bit
	always @(posedge ss_n)
		dout = ~dout;
endmodule // spm_slave_mdl
`default_nettype wire

// *** dv/spm_port_asserts.sv ***
// concurrent checks on spm_port pins: directions, select before clock, release
// assumes config ports change only while PORT_EN is low
`timescale 1ns/1ns
`default_nettype none

module spm_port_chk
	import spm_pkg::*;
(
	// clock and reset
	input wire logic                       CLK_SYS,
	input wire logic                       RST_N,
	// configuration
	input wire logic                       PORT_EN,
	input wire logic                       MASTER_SEL,
	input wire logic                       SS_DIR_OUT,
	input wire logic                       SS_OUT_EN,
	input wire logic                       THREE_WIRE,
	input wire logic                       CLK_POL,
	input wire logic [spm_pkg::HALF_W-1:0] SCK_LO,
	input wire logic                       TX_FIFO_EN,
	input wire logic                       RX_FIFO_EN,
	// control and status
	input wire logic                       START,
	input wire logic                       BUSY,
	input wire logic [spm_pkg::LVL_W-1:0]  TX_LEVEL,
	// pins
	input wire logic                       SCK_O,
	input wire logic                       SCK_OE,
	input wire logic                       MOSI_OE,
	input wire logic                       MISO_OE,
	input wire logic                       SS_N_I,
	input wire logic                       SS_N_O,
	input wire logic                       SS_N_OE
);
	logic [1:0] on_q;
	wire logic  port_on = PORT_EN && (on_q == 2'h3);
	wire logic  act     = SCK_OE && (SCK_O != CLK_POL);

	// config settled only after two enabled cycles
	always_ff @(posedge CLK_SYS) begin
		on_q <= {on_q[0], RST_N && PORT_EN};
	end

	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RST_N);

	sck_slave_a: assert property (port_on && !MASTER_SEL |-> !SCK_OE && !SS_N_OE)
		else $error("slave drives clock or select");
	miso_dir_a: assert property (port_on && MASTER_SEL |-> !MISO_OE)
		else $error("master drives master-in");
	slave_release_a: assert property (!MASTER_SEL && SS_N_I [*6] |-> !MISO_OE && !MOSI_OE)
		else $error("deselected slave still drives");
	ss_first_a: assert property (port_on && SS_OUT_EN && SS_DIR_OUT && act |-> SS_N_OE && !SS_N_O)
		else $error("clock active without select");
	sck_wait_a: assert property (port_on && SCK_LO > 8'h01 && SS_N_OE && $fell(SS_N_O)
		|-> (SCK_O == CLK_POL) [*2])
		else $error("clock moved with select");
	start_sel_a: assert property (port_on && MASTER_SEL && SS_OUT_EN && SS_DIR_OUT && START && !BUSY
		&& TX_FIFO_EN && TX_LEVEL != 5'h00 |=> BUSY && SS_N_OE && !SS_N_O)
		else $error("start did not select");
	tw_write_a: assert property (port_on && MASTER_SEL && THREE_WIRE && TX_FIFO_EN && act |-> MOSI_OE)
		else $error("shared pin not driven on write");
	tw_read_a: assert property (port_on && MASTER_SEL && THREE_WIRE && RX_FIFO_EN && !TX_FIFO_EN
		|-> !MOSI_OE)
		else $error("shared pin driven on read");
	fw_mosi_a: assert property (port_on && MASTER_SEL && !THREE_WIRE && act |-> MOSI_OE)
		else $error("master-out not driven");
	ss_dir_a: assert property (port_on && !SS_DIR_OUT |-> !SS_N_OE)
		else $error("select driven as input");

	cover property (BUSY && THREE_WIRE && !TX_FIFO_EN);
	cover property (!MASTER_SEL && MISO_OE);
	cover property (SS_N_OE && $fell(SS_N_O));
endmodule // spm_port_chk

bind spm_port spm_port_chk spm_port_chk_i (.*);
`default_nettype wire

// *** dv/tb_spm_port.sv ***
// testbench for spm_port: master runs against the slave model, slave run driven here
// assumes spm_port_chk is bound to the design
`timescale 1ns/1ns
`default_nettype none

module tb_spm_port;
	import spm_pkg::*;

	// ----------------------------------------
	// design pins and far side
	// ----------------------------------------
	logic              CLK_SYS, RST_N, PORT_EN, MASTER_SEL, SS_DIR_OUT, SS_OUT_EN, THREE_WIRE;
	logic              CLK_PHA, CLK_POL, TX_FIFO_EN, RX_FIFO_EN, START, TX_WR_VALID, RX_RD_READY;
	logic              BUSY, WAKE, TX_WR_READY, RX_RD_VALID, SCK_I, SCK_O, SCK_OE, MOSI_I, MOSI_O;
	logic              MOSI_OE, MISO_I, MISO_O, MISO_OE, SS_N_I, SS_N_O, SS_N_OE;
	logic [4:0]        CHAR_BITS, TX_WAKE_LVL, RX_WAKE_LVL, TX_LEVEL, RX_LEVEL;
	logic [HALF_W-1:0] SCK_HI, SCK_LO;
	logic [CHAR_W-1:0] TX_WR_DATA, RX_RD_DATA;
	logic              t_sck, t_ss_n, t_mosi, m_d;
	logic [15:0]       m_tx, m_got;
	logic [7:0]        q;
	int                err_total, n_checks, i;
	localparam logic [7:0] S_RX = 8'h69;

	// wire levels from all drivers
	// pins routed straight to the port function
	assign SS_N_I = SS_N_OE ? SS_N_O : t_ss_n;
	assign SCK_I  = SCK_OE ? SCK_O : t_sck;
	assign MOSI_I = MOSI_OE ? MOSI_O : (MASTER_SEL ? m_d : t_mosi);
	assign MISO_I = MISO_OE ? MISO_O : m_d;

	spm_port spm_port_i (.*);
	spm_slave_mdl spm_slave_mdl_i (.sck(SCK_I), .ss_n(SS_N_OE ? SS_N_O : 1'b1), .mosi(MOSI_I), .pol(CLK_POL),
		.pha(CLK_PHA), .nbits(CHAR_BITS), .tx_word(m_tx), .dout(m_d), .got(m_got));

	initial begin
		CLK_SYS = 1'b0;
		forever #20 CLK_SYS = ~CLK_SYS;
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic finish_test;
		if (err_total == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	function automatic logic [15:0] msk(input logic [15:0] v, input logic [4:0] n);
		return v & (16'hFFFF >> (5'h10 - n));
	endfunction

	task automatic cfg(input logic ms, tw, pha, pol, tx, rx, input logic [4:0] nb);
		PORT_EN <= 1'b0;
		@(posedge CLK_SYS);
		{MASTER_SEL, SS_DIR_OUT, SS_OUT_EN, THREE_WIRE, CLK_PHA, CLK_POL} <= {ms, ms, ms, tw, pha, pol};
		{TX_FIFO_EN, RX_FIFO_EN, CHAR_BITS, t_sck} <= {tx, rx, nb, pol};
		SCK_HI <= 8'h04 + {6'h00, pha, pol};
		repeat (2) @(posedge CLK_SYS);
		PORT_EN <= 1'b1;
		repeat (3) @(posedge CLK_SYS);
	endtask

	task automatic push(input logic [15:0] d);
		int k;
		TX_WR_VALID <= 1'b1;
		TX_WR_DATA <= d;
		for (k = 0; k < 50 && TX_WR_READY !== 1'b1; k++)
			@(posedge CLK_SYS);
		if (k == 50) begin
			$display("mismatch %0t push stuck", $time);
			err_total++;
			finish_test();
		end
		@(posedge CLK_SYS);
		TX_WR_VALID <= 1'b0;
	endtask

	task automatic pop(input logic [15:0] e, input string m);
		int k;
		for (k = 0; k < 50 && RX_RD_VALID !== 1'b1; k++)
			@(posedge CLK_SYS);
		chk({15'h0000, RX_RD_VALID}, 16'h0001, m);
		chk(RX_RD_DATA, e, m);
		RX_RD_READY <= 1'b1;
		@(posedge CLK_SYS);
		RX_RD_READY <= 1'b0;
	endtask

	task automatic go;
		int k;
		START <= 1'b1;
		@(posedge CLK_SYS);
		START <= 1'b0;
		@(posedge CLK_SYS);
		for (k = 0; k < 2000 && BUSY === 1'b1; k++)
			@(posedge CLK_SYS);
		if (k == 2000) begin
			$display("mismatch %0t busy stuck", $time);
			err_total++;
			finish_test();
		end
	endtask

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		{PORT_EN, MASTER_SEL, SS_DIR_OUT, SS_OUT_EN, THREE_WIRE, CLK_PHA, CLK_POL, TX_FIFO_EN} = '0;
		{RX_FIFO_EN, START, TX_WR_VALID, RX_RD_READY, t_sck, t_mosi, RST_N, TX_WAKE_LVL} = '0;
		{TX_WR_DATA, m_tx, q} = '0;
		{CHAR_BITS, SCK_HI, SCK_LO, RX_WAKE_LVL, t_ss_n} = {5'h08, 8'h04, 8'h04, 5'h01, 1'b1};
		repeat (8) @(posedge CLK_SYS);
		RST_N <= 1'b1;
		repeat (2) @(posedge CLK_SYS);
		chk({12'h000, SCK_OE, MOSI_OE, MISO_OE, SS_N_OE}, 16'h0000, "reset pins");
		for (i = 0; i < 6; i++) begin
			m_tx <= 16'hC3A5 + 16'(i);
			cfg(1'b1, 1'b0, i[0], i[1], 1'b1, 1'b1, (i == 4) ? 5'h01 : (i == 5) ? 5'h10 : 5'h08);
			chk({15'h0000, WAKE}, 16'h0001, "wake");
			push(16'h5A3C ^ 16'(i));
			go();
			chk(m_got, msk(16'h5A3C ^ 16'(i), CHAR_BITS), "mosi");
			pop(msk(m_tx, CHAR_BITS), "miso");
		end
		cfg(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 5'h08);
		push(16'h00E7);
		go();
		chk(m_got, 16'h00E7, "three wire write");
		m_tx <= 16'h0096;
		cfg(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 5'h08);
		go();
		pop(16'h0096, "three wire read");
		cfg(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 5'h08);
		push(16'h00B4);
		repeat (2) @(posedge CLK_SYS);
		chk({11'h000, TX_LEVEL}, 16'h0001, "tx level");
		go();
		chk({15'h0000, BUSY}, 16'h0000, "slave ignores start");
		t_ss_n <= 1'b0;
		repeat (6) @(posedge CLK_SYS);
		chk({15'h0000, MISO_OE}, 16'h0001, "slave drive");
		for (i = 7; i >= 0; i--) begin
			t_mosi <= S_RX[i];
			repeat (4) @(posedge CLK_SYS);
			q = {q[6:0], MISO_O};
			t_sck <= 1'b1;
			repeat (4) @(posedge CLK_SYS);
			t_sck <= 1'b0;
		end
		repeat (4) @(posedge CLK_SYS);
		t_ss_n <= 1'b1;
		t_mosi <= ~t_mosi;
		repeat (8) @(posedge CLK_SYS);
		chk({15'h0000, MISO_OE}, 16'h0000, "slave release");
		chk({8'h00, q}, 16'h00B4, "slave tx");
		pop({8'h00, S_RX}, "slave rx");
		finish_test();
	end
endmodule // tb_spm_port
`default_nettype wire
